// ===== hdl/svlp_axis_params.sv
// Servo axis limit and phasing parameter block
// Assumes host accesses by parameter number; position loop supplies samples
//
// Behaviour
// - Commutation mode 5 sets phase by a small test motion with no Hall input.
// - Commutation mode 6 takes phase from encoder or resolver feedback only.
// - Commutation mode 7 commutates trapezoidally and interpolates between Hall edges.
// - Analog encoder scaling sets analog encoder resolution and is ignored otherwise.
// - Phase-capable feedback exposes its computed phase angle for reading.
// - Each successful homing stores its position correction as the homing adjustment.
// - In phase-voltage mode the PWM frequency setting counts in 10 Hz steps.
// - In other PWM modes the setting is a deadband, 0..32767 mapping to 0..100 percent.
// - Writing the frequency parameter also changes the dedicated deadband value.
// - A read-only counter holds milliseconds since start-up.
// - Software limits apply only once homing has completed.
// - The positive limit is off when set below the negative limit.
// - The negative limit is off when set above the positive limit.
// - Loop error beyond the fault limit sets event bit 18 and stops the motor.
// - The fault mask chooses disable or the alternative following-error action.
// - The alternative action aborts the move and holds position.
`timescale 1ns/100ps
module svlp_axis_params
    import svlp_pkg::*;
#(
    parameter int CYCLES_PER_MS = SVLP_CYCLES_PER_MS,
    parameter int WIGGLE_CYCLES = 1024
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    // Parameter port
    input  wire logic               par_wr,
    input  wire logic               par_rd,
    input  wire logic [8:0]         par_addr,
    input  wire logic [31:0]        par_wdata,
    output logic [31:0]             par_rdata,
    output logic                    par_ack,
    output logic                    par_err,
    // Configuration set elsewhere
    input  wire logic               analog_encoder,
    input  wire logic               phase_voltage_command_mode,
    input  wire logic               has_deadband_param,
    input  wire logic [15:0]        analog_scale_cfg,
    // Position loop
    input  wire logic               loop_update,
    input  wire logic signed [31:0] actual_pos,
    input  wire logic signed [31:0] loop_error,
    input  wire logic               homing_done,
    input  wire logic signed [31:0] homing_correction,
    // Feedback pins
    input  wire logic [2:0]         hall_pin,
    input  wire logic [15:0]        enc_angle,
    input  wire logic [15:0]        interp_step,
    input  wire logic               phase_start,
    // Drive outputs
    output logic [15:0]             phase_angle,
    output logic                    wiggle_active,
    output logic                    phase_valid,
    output logic                    pos_limit_hit,
    output logic                    neg_limit_hit,
    output logic                    drive_disable,
    output logic                    abort_hold,
    output logic [31:0]             pwm_freq_hz,
    output logic [15:0]             deadband_cfg,
    output logic [15:0]             analog_enc_res,
    output logic [31:0]             system_time_ms
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0]        pwm_freq_q;
    logic [15:0]        deadband_q;
    logic signed [31:0] pos_lim_q;
    logic signed [31:0] neg_lim_q;
    logic signed [31:0] fe_lim_q;
    logic [31:0]        home_adj_q;
    logic [31:0]        event_q;
    logic [31:0]        fault_mask_q;
    logic [2:0]         commut_q;
    logic               homed_q;
    logic               pos_hit_q;
    logic               neg_hit_q;
    logic               disable_q;
    logic               abort_q;
    logic [31:0]        rdata_q;
    logic               ack_q;
    logic               err_q;
    logic [2:0]         hall_s1_q;
    logic [2:0]         hall_s2_q;
    logic [31:0]        time_ms;
    logic [15:0]        ph_angle;

    // ------------------------------------------------------------
    // Hall synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hall_s1_q <= 3'h0;
            hall_s2_q <= 3'h0;
        end else begin
            hall_s1_q <= hall_pin;
            hall_s2_q <= hall_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    svlp_ms_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_timer (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .time_ms (time_ms),
        .ms_tick ()
    );

    svlp_phasing #(
        .WIGGLE_CYCLES (WIGGLE_CYCLES)
    ) u_phasing (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .mode          (svlp_commut_t'(commut_q)),
        .start         (phase_start),
        .hall          (hall_s2_q),
        .enc_angle     (enc_angle),
        .interp_step   (interp_step),
        .phase_angle   (ph_angle),
        .wiggle_active (wiggle_active),
        .phase_valid   (phase_valid)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic is_addr(input logic [8:0] a, input logic [8:0] b);
        is_addr = (a == b);
    endfunction

    wire wr_freq = par_wr && is_addr(par_addr, SVLP_ADDR_PWM_INPUT_FREQ);
    wire wr_db   = par_wr && is_addr(par_addr, SVLP_ADDR_PWM_DEADBAND) && has_deadband_param;
    wire wr_pos  = par_wr && is_addr(par_addr, SVLP_ADDR_POS_SOFT_LIMIT);
    wire wr_neg  = par_wr && is_addr(par_addr, SVLP_ADDR_NEG_SOFT_LIMIT);
    wire wr_fe   = par_wr && is_addr(par_addr, SVLP_ADDR_FOLLOW_ERR_LIMIT);
    wire wr_cm   = par_wr && is_addr(par_addr, SVLP_ADDR_COMMUT_MODE);
    wire wr_mask = par_wr && is_addr(par_addr, SVLP_ADDR_FAULT_MASK);
    wire wr_evt  = par_wr && is_addr(par_addr, SVLP_ADDR_EVENT_STATUS);
    wire wr_ok   = wr_freq | wr_db | wr_pos | wr_neg | wr_fe | wr_cm | wr_mask | wr_evt;

    wire [15:0] analog_res = analog_encoder ? analog_scale_cfg : SVLP_RST_ANALOG_SCALE;
    wire [15:0] enc_phase  = enc_angle;

    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        if (is_addr(par_addr, SVLP_ADDR_ANALOG_ENC_SCALE)) begin
            rd_mux = {16'h0, analog_res};
        end else if (is_addr(par_addr, SVLP_ADDR_ENC_PHASE_ANGLE)) begin
            rd_mux = {16'h0, enc_phase};
        end else if (is_addr(par_addr, SVLP_ADDR_HOMING_ADJUST)) begin
            rd_mux = home_adj_q;
        end else if (is_addr(par_addr, SVLP_ADDR_PWM_INPUT_FREQ)) begin
            rd_mux = {16'h0, pwm_freq_q};
        end else if (is_addr(par_addr, SVLP_ADDR_SYSTEM_TIME_MS)) begin
            rd_mux = time_ms;
        end else if (is_addr(par_addr, SVLP_ADDR_POS_SOFT_LIMIT)) begin
            rd_mux = pos_lim_q;
        end else if (is_addr(par_addr, SVLP_ADDR_NEG_SOFT_LIMIT)) begin
            rd_mux = neg_lim_q;
        end else if (is_addr(par_addr, SVLP_ADDR_FOLLOW_ERR_LIMIT)) begin
            rd_mux = fe_lim_q;
        end else if (is_addr(par_addr, SVLP_ADDR_PWM_DEADBAND) && has_deadband_param) begin
            rd_mux = {16'h0, deadband_q};
        end else if (is_addr(par_addr, SVLP_ADDR_COMMUT_MODE)) begin
            rd_mux = {29'h0, commut_q};
        end else if (is_addr(par_addr, SVLP_ADDR_FAULT_MASK)) begin
            rd_mux = fault_mask_q;
        end else if (is_addr(par_addr, SVLP_ADDR_EVENT_STATUS)) begin
            rd_mux = event_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Limit and following-error checks
    // ------------------------------------------------------------
    wire               pos_en   = homed_q && !(pos_lim_q < neg_lim_q);
    wire               neg_en   = homed_q && !(neg_lim_q > pos_lim_q);
    wire signed [31:0] err_mag  = loop_error[31] ? -loop_error : loop_error;
    wire               fe_trip  = loop_update && (err_mag > fe_lim_q);
    wire               fe_dis   = fault_mask_q[SVLP_MASK_FOLLOW_ERR_BIT];
    wire               evt_clr  = wr_evt && par_wdata[SVLP_EVT_FOLLOW_ERR_BIT];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_hit_q <= 1'b0;
            neg_hit_q <= 1'b0;
        end else if (loop_update) begin
            pos_hit_q <= pos_en && (actual_pos > pos_lim_q);
            neg_hit_q <= neg_en && (actual_pos < neg_lim_q);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            event_q   <= 32'h0;
            disable_q <= 1'b0;
            abort_q   <= 1'b0;
        end else begin
            // Set wins over clear
            event_q[SVLP_EVT_FOLLOW_ERR_BIT] <= fe_trip || (event_q[SVLP_EVT_FOLLOW_ERR_BIT] && !evt_clr);
            disable_q <= (fe_trip && fe_dis) || (disable_q && !evt_clr);
            abort_q   <= (fe_trip && !fe_dis) || (abort_q && !evt_clr);
        end
    end

    // ------------------------------------------------------------
    // Parameter writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_freq_q   <= SVLP_RST_PWM_FREQ;
            deadband_q   <= SVLP_RST_PWM_FREQ;
            pos_lim_q    <= SVLP_RST_POS_LIMIT;
            neg_lim_q    <= SVLP_RST_NEG_LIMIT;
            fe_lim_q     <= SVLP_RST_FOLLOW_LIMIT;
            fault_mask_q <= 32'h0;
            commut_q     <= 3'h0;
        end else begin
            if (wr_freq) pwm_freq_q <= par_wdata[15:0];
            if (wr_freq || wr_db) deadband_q <= par_wdata[15:0];
            if (wr_pos) pos_lim_q <= par_wdata;
            if (wr_neg) neg_lim_q <= par_wdata;
            if (wr_fe) fe_lim_q <= par_wdata;
            if (wr_mask) fault_mask_q <= par_wdata;
            if (wr_cm) commut_q <= par_wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            home_adj_q <= 32'h0;
            homed_q    <= 1'b0;
        end else if (homing_done) begin
            home_adj_q <= homing_correction;
            homed_q    <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // PWM input interpretation
    // ------------------------------------------------------------
    wire [31:0] freq_hz  = 32'(pwm_freq_q) * 32'(SVLP_PWM_FREQ_STEP_HZ);
    wire [15:0] db_sat   = (deadband_q > SVLP_DEADBAND_FULL) ? SVLP_DEADBAND_FULL : deadband_q;

    // ------------------------------------------------------------
    // Answer and outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h0;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= (par_rd && rd_hit) ? rd_mux : 32'h0;
            ack_q   <= par_rd || par_wr;
            err_q   <= (par_rd && !rd_hit) || (par_wr && !wr_ok);
        end
    end

    assign par_rdata      = rdata_q;
    assign par_ack        = ack_q;
    assign par_err        = err_q;
    assign phase_angle    = ph_angle;
    assign pos_limit_hit  = pos_hit_q;
    assign neg_limit_hit  = neg_hit_q;
    assign drive_disable  = disable_q;
    assign abort_hold     = abort_q;
    assign pwm_freq_hz    = phase_voltage_command_mode ? freq_hz : 32'h0;
    assign deadband_cfg   = phase_voltage_command_mode ? 16'h0 : db_sat;
    assign analog_enc_res = analog_res;
    assign system_time_ms = time_ms;

endmodule

// ===== hdl/svlp_ms_timer.sv
// Millisecond system time counter
// Assumes ref_clk at the rate named in the package
`timescale 1ns/100ps
module svlp_ms_timer
    import svlp_pkg::*;
#(
    parameter int CYCLES_PER_MS = SVLP_CYCLES_PER_MS
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Time outputs
    output logic [31:0]      time_ms,
    output logic             ms_tick
);

    logic [17:0] div_q;
    logic [31:0] time_q;
    wire         wrap = (div_q == 18'(CYCLES_PER_MS - 1));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q  <= 18'h0;
            time_q <= 32'h0;
        end else begin
            div_q  <= wrap ? 18'h0 : div_q + 18'h1;
            time_q <= wrap ? time_q + 32'h1 : time_q;
        end
    end

    assign time_ms = time_q;
    assign ms_tick = wrap;

endmodule

// ===== hdl/svlp_phasing.sv
// Commutation phase angle generator for modes 5, 6 and 7
// Assumes hall and encoder inputs already synchronised
`timescale 1ns/100ps
module svlp_phasing
    import svlp_pkg::*;
#(
    parameter int WIGGLE_CYCLES = 1024
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    // Mode and feedback
    input  wire svlp_commut_t mode,
    input  wire logic         start,
    input  wire logic [2:0]   hall,
    input  wire logic [15:0]  enc_angle,
    input  wire logic [15:0]  interp_step,
    // Outputs
    output logic [15:0]       phase_angle,
    output logic              wiggle_active,
    output logic              phase_valid
);

    svlp_phase_st_t st_q;
    logic [15:0]    ang_q;
    logic [15:0]    off_q;
    logic [15:0]    cnt_q;
    logic [2:0]     hall_q;

    // Hall sector to base angle
    function automatic logic [15:0] sector_angle(input logic [2:0] h);
        case (h)
            3'h1:    sector_angle = 16'h0000;
            3'h3:    sector_angle = 16'h2aab;
            3'h2:    sector_angle = 16'h5555;
            3'h6:    sector_angle = 16'h8000;
            3'h4:    sector_angle = 16'haaab;
            3'h5:    sector_angle = 16'hd555;
            default: sector_angle = 16'h0000;
        endcase
    endfunction

    wire hall_edge = (hall != hall_q);
    wire wig_end   = (cnt_q == 16'(WIGGLE_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= SVLP_PH_IDLE;
            ang_q  <= 16'h0;
            off_q  <= 16'h0;
            cnt_q  <= 16'h0;
            hall_q <= 3'h0;
        end else begin
            hall_q <= hall;
            case (mode)
                SVLP_CM_ALGORITHMIC: begin
                    case (st_q)
                        SVLP_PH_IDLE: begin
                            cnt_q <= 16'h0;
                            if (start) st_q <= SVLP_PH_WIGGLE;
                        end
                        SVLP_PH_WIGGLE: begin
                            cnt_q <= cnt_q + 16'h1;
                            ang_q <= {cnt_q[5] ? 8'h04 : 8'hfc, 8'h00};
                            if (wig_end) st_q <= SVLP_PH_SETTLE;
                        end
                        SVLP_PH_SETTLE: begin
                            off_q <= 16'h0 - enc_angle;
                            st_q  <= SVLP_PH_DONE;
                        end
                        default: ang_q <= enc_angle + off_q;
                    endcase
                end
                SVLP_CM_ENCODER: begin
                    ang_q <= enc_angle;
                    st_q  <= SVLP_PH_DONE;
                end
                SVLP_CM_TRAP_INTERP: begin
                    ang_q <= hall_edge ? sector_angle(hall) : ang_q + interp_step;
                    st_q  <= SVLP_PH_DONE;
                end
                default: begin
                    ang_q <= sector_angle(hall);
                    st_q  <= SVLP_PH_IDLE;
                end
            endcase
        end
    end

    assign phase_angle   = ang_q;
    assign wiggle_active = (st_q == SVLP_PH_WIGGLE);
    assign phase_valid   = (st_q == SVLP_PH_DONE);

endmodule

// ===== hdl/svlp_pkg.sv
// Package for the servo limit and phasing parameter block
// Assumes a 200 MHz ref_clk and a parameter-number register port
package svlp_pkg;

    // ------------------------------------------------------------
    // Parameter numbers
    // ------------------------------------------------------------
    localparam logic [8:0] SVLP_ADDR_ANALOG_ENC_SCALE = 9'h0b3;
    localparam logic [8:0] SVLP_ADDR_ENC_PHASE_ANGLE  = 9'h0b4;
    localparam logic [8:0] SVLP_ADDR_HOMING_ADJUST    = 9'h0b5;
    localparam logic [8:0] SVLP_ADDR_PWM_INPUT_FREQ   = 9'h0b6;
    localparam logic [8:0] SVLP_ADDR_SYSTEM_TIME_MS   = 9'h0b7;
    localparam logic [8:0] SVLP_ADDR_POS_SOFT_LIMIT   = 9'h0b8;
    localparam logic [8:0] SVLP_ADDR_NEG_SOFT_LIMIT   = 9'h0b9;
    localparam logic [8:0] SVLP_ADDR_FOLLOW_ERR_LIMIT = 9'h0ba;
    localparam logic [8:0] SVLP_ADDR_PWM_DEADBAND     = 9'h13f;
    localparam logic [8:0] SVLP_ADDR_COMMUT_MODE      = 9'h0b2;
    localparam logic [8:0] SVLP_ADDR_FAULT_MASK       = 9'h0a7;
    localparam logic [8:0] SVLP_ADDR_EVENT_STATUS     = 9'h0a0;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          SVLP_EVT_FOLLOW_ERR_BIT  = 18;
    localparam int          SVLP_MASK_FOLLOW_ERR_BIT = 18;
    localparam logic [31:0] SVLP_RST_POS_LIMIT       = 32'h0000_0000;
    localparam logic [31:0] SVLP_RST_NEG_LIMIT       = 32'h0000_0000;
    localparam logic [31:0] SVLP_RST_FOLLOW_LIMIT    = 32'h7fff_ffff;
    localparam logic [15:0] SVLP_RST_PWM_FREQ        = 16'h0000;
    localparam logic [15:0] SVLP_RST_ANALOG_SCALE    = 16'h0000;
    localparam logic [15:0] SVLP_DEADBAND_FULL       = 16'h7fff;
    localparam logic [15:0] SVLP_PWM_FREQ_STEP_HZ    = 16'h000a;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SVLP_CLK_HZ       = 200_000_000;
    localparam int SVLP_TICK_MS      = 1;
    localparam int SVLP_CYCLES_PER_MS = SVLP_CLK_HZ / 1000 * SVLP_TICK_MS;

    // ------------------------------------------------------------
    // Commutation modes and phasing states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SVLP_CM_HALL_SINE   = 3'h0,
        SVLP_CM_HALL_TRAP   = 3'h1,
        SVLP_CM_HALL_INIT   = 3'h2,
        SVLP_CM_ANALOG_HALL = 3'h3,
        SVLP_CM_DC_BRUSH    = 3'h4,
        SVLP_CM_ALGORITHMIC = 3'h5,
        SVLP_CM_ENCODER     = 3'h6,
        SVLP_CM_TRAP_INTERP = 3'h7
    } svlp_commut_t;

    typedef enum logic [1:0] {
        SVLP_PH_IDLE   = 2'b00,
        SVLP_PH_WIGGLE = 2'b01,
        SVLP_PH_SETTLE = 2'b11,
        SVLP_PH_DONE   = 2'b10
    } svlp_phase_st_t;

endpackage

// ===== test/svlp_axis_params_props.sv
// Checker for the servo axis parameter block
// Assumes binding to svlp_axis_params by port name
`timescale 1ns/100ps
module svlp_axis_params_props
    import svlp_pkg::*;
(
    // Clock, reset and parameter port
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        par_wr,
    input wire logic        par_rd,
    input wire logic [8:0]  par_addr,
    input wire logic        par_ack,
    input wire logic        par_err,
    // Drive side
    input wire logic        phase_voltage_command_mode,
    input wire logic        loop_update,
    input wire logic        drive_disable,
    input wire logic        abort_hold,
    input wire logic [31:0] pwm_freq_hz,
    input wire logic [15:0] deadband_cfg,
    input wire logic [31:0] system_time_ms
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    read_ack_a: assert property (par_rd |=> par_ack)
        else $error("read not answered");
    ack_cause_a: assert property (par_ack |-> $past(par_rd || par_wr))
        else $error("answer without request");
    time_ro_a: assert property (par_wr && par_addr == SVLP_ADDR_SYSTEM_TIME_MS |=> par_ack && par_err)
        else $error("time write not refused");
    time_step_a: assert property ($changed(system_time_ms) |-> system_time_ms == $past(system_time_ms) + 32'h1)
        else $error("time skipped");
    pwm_mode_a: assert property (!phase_voltage_command_mode |-> pwm_freq_hz == 32'h0)
        else $error("frequency outside its mode");
    deadband_max_a: assert property (deadband_cfg <= SVLP_DEADBAND_FULL)
        else $error("deadband above full scale");
    fault_cause_a: assert property ($rose(drive_disable) |-> $past(loop_update))
        else $error("disable without loop update");
    abort_cause_a: assert property ($rose(abort_hold) |-> $past(loop_update) && !drive_disable)
        else $error("hold without loop update");
    cover property ($rose(drive_disable));
    cover property ($rose(abort_hold));
    cover property (par_wr ##3 par_rd);
endmodule
bind svlp_axis_params svlp_axis_params_props chk_u (.*);

// ===== test/svlp_host_model.sv
// Host controller model on the parameter port
// Assumes the answer comes one cycle after the strobe edge
`timescale 1ns/100ps
module svlp_host_model (
    // Clock
    input  wire logic        ref_clk,
    // Parameter port
    output logic             par_wr,
    output logic             par_rd,
    output logic [8:0]       par_addr,
    output logic [31:0]      par_wdata,
    input  wire logic [31:0] par_rdata,
    input  wire logic        par_ack,
    input  wire logic        par_err
);
    initial begin
        par_wr = 1'b0;
        par_rd = 1'b0;
        par_addr = 9'h0;
        par_wdata = 32'h0;
    end
    task automatic access(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q,
                          output logic e);
        @(posedge ref_clk);
        par_wr <= w;
        par_rd <= !w;
        par_addr <= a;
        par_wdata <= d;
        @(posedge ref_clk);
        par_wr <= 1'b0;
        par_rd <= 1'b0;
        par_addr <= ~a;
        par_wdata <= ~d;
        @(posedge ref_clk);
        q = par_ack ? par_rdata : 32'hx;
        e = par_ack ? par_err : 1'bx;
    endtask
endmodule

// ===== test/tb_servo_limit_and_phasing_params.sv
// Testbench for the servo axis parameter block
// Assumes the host model on the parameter port and the bound checker
`timescale 1ns/100ps
module tb_servo_limit_and_phasing_params;
    localparam logic [31:0] nil = 32'h0;
    logic ref_clk, par_wr, par_rd, par_ack, par_err, wiggle_active, phase_valid, e;
    logic pos_limit_hit, neg_limit_hit, drive_disable, abort_hold;
    logic [8:0] par_addr;
    logic [31:0] par_wdata, par_rdata, pwm_freq_hz, system_time_ms, q;
    logic [15:0] phase_angle, deadband_cfg, analog_enc_res;
    logic rst_b = 1'b0, analog_encoder = 1'b0, phase_voltage_command_mode = 1'b0, has_deadband_param = 1'b1;
    logic loop_update = 1'b0, homing_done = 1'b0, phase_start = 1'b0;
    logic [15:0] analog_scale_cfg = 16'h1234, enc_angle = 16'h1357, interp_step = 16'h10;
    logic signed [31:0] actual_pos = 32'h0, loop_error = 32'h0, homing_correction = 32'hffff_fff3;
    logic [2:0] hall_pin = 3'h1;
    int errors = 0, total_checks = 0, n;
    svlp_axis_params #(.CYCLES_PER_MS(10), .WIGGLE_CYCLES(8)) dut_u (.*);
    svlp_host_model host_u (.ref_clk(ref_clk), .par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr),
        .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask
    // Read compares data; write compares only the refusal flag
    task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [31:0] x = nil,
                       input logic xe = 1'b0);
        host_u.access(w, a, d, q, e);
        chk("par_err", 32'(e), 32'(xe));
        if (!w) chk("par_rdata", q, x);
    endtask
    task automatic lu(input logic [31:0] p, input logic [31:0] le);
        @(posedge ref_clk);
        loop_update <= 1'b1;
        actual_pos <= p;
        loop_error <= le;
        @(posedge ref_clk);
        loop_update <= 1'b0;
        #1;
    endtask
    task automatic results();
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        acc(1'b1, 9'h0b7, 32'h5, nil, 1'b1);
        acc(1'b0, 9'h0b3, nil, nil);
        @(posedge ref_clk) analog_encoder <= 1'b1;
        acc(1'b0, 9'h0b3, nil, 32'h1234);
        chk("analog_enc_res", 32'(analog_enc_res), 32'h1234);
        @(posedge ref_clk) phase_voltage_command_mode <= 1'b1;
        acc(1'b1, 9'h0b6, 32'h64);
        chk("pwm_freq_hz", pwm_freq_hz, 32'h3e8);
        @(posedge ref_clk) phase_voltage_command_mode <= 1'b0;
        acc(1'b1, 9'h0b6, 32'h9000);
        chk("deadband_cfg", 32'(deadband_cfg), 32'h7fff);
        acc(1'b1, 9'h0b8, 32'h64);
        acc(1'b1, 9'h0b9, 32'hffff_ff9c);
        lu(32'hc8, nil);
        chk("pos_limit_hit", 32'(pos_limit_hit), nil);
        @(posedge ref_clk) homing_done <= 1'b1;
        @(posedge ref_clk) homing_done <= 1'b0;
        acc(1'b0, 9'h0b5, nil, 32'hffff_fff3);
        lu(32'hc8, nil);
        chk("pos_limit_hit", 32'(pos_limit_hit), 32'h1);
        acc(1'b1, 9'h0b8, 32'hffff_ff38);
        lu(32'hc8, nil);
        chk("pos_limit_hit", 32'(pos_limit_hit), nil);
        acc(1'b1, 9'h0b9, 32'h96);
        lu(32'hffff_ff38, nil);
        chk("neg_limit_hit", 32'(neg_limit_hit), nil);
        acc(1'b1, 9'h0ba, 32'h32);
        acc(1'b1, 9'h0a7, 32'h4_0000);
        lu(nil, 32'h33);
        chk("drive_disable", 32'(drive_disable), 32'h1);
        acc(1'b0, 9'h0a0, nil, 32'h4_0000);
        acc(1'b1, 9'h0a0, 32'h4_0000);
        acc(1'b1, 9'h0a7, nil);
        lu(nil, 32'hffff_ffc4);
        chk("abort_hold", 32'(abort_hold), 32'h1);
        acc(1'b1, 9'h0b2, 32'h5);
        @(posedge ref_clk) phase_start <= 1'b1;
        @(posedge ref_clk) phase_start <= 1'b0;
        for (n = 0; n < 40 && wiggle_active !== 1'b1; n++) @(posedge ref_clk);
        chk("wiggle_active", 32'(wiggle_active), 32'h1);
        for (n = 0; n < 40 && phase_valid !== 1'b1; n++) @(posedge ref_clk);
        chk("phase_valid", 32'(phase_valid), 32'h1);
        acc(1'b1, 9'h0b2, 32'h6);
        for (n = 0; n < 8 && phase_angle !== enc_angle; n++) @(posedge ref_clk);
        chk("phase_angle", 32'(phase_angle), 32'h1357);
        acc(1'b0, 9'h0b4, nil, 32'h1357);
        acc(1'b1, 9'h0b2, 32'h7);
        n = int'(phase_angle);
        @(posedge ref_clk);
        chk("phase_angle", 32'(phase_angle), 32'(16'(n + 'h10)));
        n = int'(system_time_ms);
        repeat (10) @(posedge ref_clk);
        chk("system_time_ms", system_time_ms, 32'(n + 1));
        results();
    end
    // Whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        results();
    end
endmodule
